// [src/pelb_regs.vh]
/*
  Constants for the per-thread event strobe block: thread counts, event vector
  positions and widths. Included by every design file of the block except the synchroniser; defines only.
*/
// Function
// - L1-starved demand requests count as prefetch
// - Hardware sequential prefetches count as prefetch
// - Count miss cycles until data, per class
// - Count demand misses; outstanding-line hits excluded
// - Demand references: no retries, once per flow
// - Foreign copyback/invalidate never count as demand
// - Prefetch references include software and hardware
// - Count demand misses carrying writeback
// - Count prefetch misses carrying writeback
// - Split demand misses: fetch, shared, exclusive
// - Count exclusive requests hitting shared/owned lines
// - Count dropped software prefetches, two causes
// - Count each incoming bus request type
// - Count one-subline and four-subline replies
// - Order-bus aggregate ORs four buses, bus cycles
// - Request-bus aggregate ORs four buses, core cycles
// - Separate busy event per controller bus
// - Single-thread active cycles and committed instructions
// - Both active, both commit stacks nonempty
// - Both active, both commit stacks empty
// - Count three suspension state conditions
// - Stall events sampled at commit stage
// - Only triggering thread counts; bus events all
`ifndef PELB_REGS_VH
`define PELB_REGS_VH
`define PELB_THREADS 8
`define PELB_TID_W 3
`define PELB_BUSES 4
`define PELB_CMT_W 3
// Per-thread cache event vector positions.
`define PELB_L2_W 16
`define PELB_EV_DM_LAT 0
`define PELB_EV_PF_LAT 1
`define PELB_EV_DM_MISS 2
`define PELB_EV_PF_MISS 3
`define PELB_EV_DM_REF 4
`define PELB_EV_PF_REF 5
`define PELB_EV_DM_WB 6
`define PELB_EV_PF_WB 7
`define PELB_EV_IF_MISS 8
`define PELB_EV_SH_MISS 9
`define PELB_EV_EX_MISS 10
`define PELB_EV_EX_UPG 11
`define PELB_EV_DROP_FULL 12
`define PELB_EV_DROP_ABORT 13
// Shared bus event vector positions.
`define PELB_BUS_W 16
`define PELB_EV_INV 0
`define PELB_EV_CPI 1
`define PELB_EV_CPB 2
`define PELB_EV_IORD 3
`define PELB_EV_REP1 4
`define PELB_EV_REP4 5
`define PELB_EV_ODR_SUM 6
`define PELB_EV_REQ_SUM 7
`define PELB_EV_ODR0 8
`define PELB_EV_REQ0 12
// Request kinds from the cache pipeline.
`define PELB_KIND_W 2
`define PELB_KIND_FETCH 2'h0
`define PELB_KIND_SHARED 2'h1
`define PELB_KIND_EXCL 2'h2
// Per-thread pairing/commit event vector positions.
`define PELB_MT_W 8
`define PELB_EV_SGL_CYC 0
`define PELB_EV_SGL_INS 1
`define PELB_EV_BOTH_ACT 2
`define PELB_EV_BOTH_EMP 3
`define PELB_EV_BOTH_SUS 4
`define PELB_EV_ONLY_ME 5
`define PELB_EV_ME_SUS 6
`define PELB_EV_CMT_STALL 7
`endif

// [src/pelb_sync2.v]
/*
  Two-stage synchroniser for a vector of levels.
  Assumes each bit is a level that stays stable for at least two clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module pelb_sync2 #(
  parameter W = 4
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff; // First stage; only the second stage reads it.
  reg [W-1:0] sync_ff; // Second stage, safe to use.

  // Both stages clear on reset so downstream sees idle buses.
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// [src/pelb_miss_tracker.v]
/*
  Outstanding second-level miss tracker: one slot per miss tag, holding the
  class (demand or prefetch) until data returns. Assumes the cache pipeline
  allocates a tag at miss and returns the same tag with the data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pelb_regs.vh"
module pelb_miss_tracker #(
  parameter SLOTS = 8,
  parameter TAG_W = 3
) (
  input wire clk,
  input wire rst,
  input wire alloc,
  input wire [TAG_W-1:0] alloc_tag,
  input wire alloc_pf,
  input wire [`PELB_TID_W-1:0] alloc_tid,
  input wire done,
  input wire [TAG_W-1:0] done_tag,
  output reg [`PELB_THREADS-1:0] dm_wait,
  output reg [`PELB_THREADS-1:0] pf_wait
);
  reg [SLOTS-1:0] busy_ff; // Slot holds a miss awaiting data.
  reg [SLOTS-1:0] pf_ff; // Slot class: 1 for prefetch.
  reg [`PELB_TID_W-1:0] tid_ff [0:SLOTS-1]; // Owning thread of each slot.
  integer i; // Loop index of the clocked process.
  integer j; // Loop index of the decode; each process owns its own index.

  // Allocation wins over a return to the same slot, so a reused tag is kept.
  always @(posedge clk) begin
    if (rst) begin
      busy_ff <= {SLOTS{1'b0}};
      pf_ff <= {SLOTS{1'b0}};
      for (i = 0; i < SLOTS; i = i + 1) begin
        tid_ff[i] <= {`PELB_TID_W{1'b0}};
      end
    end else begin
      if (done) begin
        busy_ff[done_tag] <= 1'b0;
      end
      if (alloc) begin
        busy_ff[alloc_tag] <= 1'b1;
        pf_ff[alloc_tag] <= alloc_pf;
        tid_ff[alloc_tag] <= alloc_tid;
      end
    end
  end

  // Any busy slot makes its thread's latency strobe high that cycle; the
  // latency event counts cycles, not misses, so overlap collapses to one.
  always @* begin
    dm_wait = {`PELB_THREADS{1'b0}};
    pf_wait = {`PELB_THREADS{1'b0}};
    for (j = 0; j < SLOTS; j = j + 1) begin
      if (busy_ff[j] && pf_ff[j]) begin
        pf_wait[tid_ff[j]] = 1'b1;
      end
      if (busy_ff[j] && !pf_ff[j]) begin
        dm_wait[tid_ff[j]] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [src/pelb_event_gen.v]
/*
  Performance event strobe generator for the second-level cache, system bus
  and thread-pairing events. Every output comes from a flip-flop for the counter bank:
  one-bit strobes, plus the commit counts in sgl_ins_cnt_ff. Assumes cache and commit inputs are on clk;
  bus busy levels and the order-bus tick come from the bus clock and are
  resynchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pelb_regs.vh"
module pelb_event_gen (
  input wire clk,
  input wire rst,
  // Second-level cache access report, one per pipeline flow.
  input wire l2_acc_valid,
  input wire [`PELB_TID_W-1:0] l2_acc_tid,
  input wire l2_acc_sw_pf,
  input wire l2_acc_hw_pf,
  input wire l2_acc_l1_starved,
  input wire l2_acc_read,
  input wire l2_acc_retry,
  input wire l2_acc_foreign,
  input wire [`PELB_KIND_W-1:0] l2_acc_kind,
  input wire l2_acc_miss,
  input wire l2_acc_line_pending,
  input wire l2_acc_writeback,
  input wire l2_acc_hit_shared_owned,
  input wire [2:0] l2_acc_miss_tag,
  input wire l2_data_return,
  input wire [2:0] l2_data_tag,
  // Dropped software prefetches.
  input wire swpf_drop_full,
  input wire swpf_drop_abort,
  input wire [`PELB_TID_W-1:0] swpf_drop_tid,
  // Bus requests and replies, one-cycle strobes on clk.
  input wire invalidations_received,
  input wire copy_invalidate_received,
  input wire copyback_received,
  input wire io_read_received,
  input wire reply_one_subline,
  input wire reply_four_sublines,
  // Busy levels from the bus clock domain.
  input wire [`PELB_BUSES-1:0] order_bus_busy,
  input wire order_bus_tick,
  input wire [`PELB_BUSES-1:0] request_bus_busy,
  // Thread state, per thread, on clk.
  input wire [`PELB_THREADS-1:0] thread_active,
  input wire [`PELB_THREADS-1:0] thread_single_mode,
  input wire [`PELB_THREADS-1:0] commit_stack_nonempty,
  input wire [`PELB_THREADS-1:0] commit_stall,
  input wire [`PELB_THREADS*`PELB_CMT_W-1:0] commit_count,
  // Strobes to the counter bank.
  output reg [`PELB_THREADS*`PELB_L2_W-1:0] l2_ev_ff,
  output reg [`PELB_BUS_W-1:0] bus_ev_ff,
  output reg [`PELB_THREADS-1:0] bus_ev_all_ff,
  output reg [`PELB_THREADS*`PELB_MT_W-1:0] mt_ev_ff,
  output reg [`PELB_THREADS*`PELB_CMT_W-1:0] sgl_ins_cnt_ff
);
  wire [`PELB_BUSES-1:0] odr_busy_s; // Order-bus busy after sync.
  wire [`PELB_BUSES-1:0] req_busy_s; // Request-bus busy after sync.
  wire tick_s; // Order-bus clock tick level after sync.
  wire [`PELB_THREADS-1:0] dm_wait;
  wire [`PELB_THREADS-1:0] pf_wait;
  reg tick_d_ff; // Previous synced tick, for edge detection.
  reg [`PELB_THREADS*`PELB_L2_W-1:0] nxt_l2_ev;
  reg [`PELB_BUS_W-1:0] nxt_bus_ev;
  reg [`PELB_THREADS*`PELB_MT_W-1:0] nxt_mt_ev;
  reg [`PELB_THREADS*`PELB_CMT_W-1:0] nxt_sgl_ins;
  reg is_pf; // Current access counts in the prefetch class.
  reg dm_miss; // Current access is a countable demand miss.
  reg pf_miss; // Current access is a countable prefetch miss.
  reg [`PELB_TID_W-1:0] mate; // Sibling thread in the core.
  reg odr_edge; // One bus-clock cycle has elapsed.
  integer t; // Thread index of the pairing loop.
  integer u; // Thread index of the latency loop; one loop variable per process.
  integer b;

  // Busy levels cross from the bus clock, so each passes two flops first.
  pelb_sync2 #(
    .W(2*`PELB_BUSES+1)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({order_bus_tick, order_bus_busy, request_bus_busy}),
    .q({tick_s, odr_busy_s, req_busy_s})
  );

  pelb_miss_tracker #(
    .SLOTS(8),
    .TAG_W(3)
  ) u_trk (
    .clk(clk),
    .rst(rst),
    .alloc(dm_miss || pf_miss), // Foreign flows never open a latency window.
    .alloc_tag(l2_acc_miss_tag),
    .alloc_pf(is_pf),
    .alloc_tid(l2_acc_tid),
    .done(l2_data_return),
    .done_tag(l2_data_tag),
    .dm_wait(dm_wait),
    .pf_wait(pf_wait)
  );

  // Index of a per-thread event bit inside a flat vector.
  function integer ev_idx;
    input integer tid;
    input integer width;
    input integer pos;
    begin
      ev_idx = tid * width + pos;
    end
  endfunction

  // Number of set bits; used for both bus aggregates.
  function [2:0] pop4;
    input [`PELB_BUSES-1:0] v;
    begin
      pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    end
  endfunction

  // Classification and strobe assembly for the cache events.
  always @* begin
    // Starved demand and hardware prefetch both land in the prefetch class.
    is_pf = l2_acc_sw_pf || l2_acc_hw_pf || l2_acc_l1_starved;
    // A line already in flight counts as a hit, and retries never count.
    dm_miss = l2_acc_valid && !l2_acc_retry && l2_acc_miss && !l2_acc_line_pending
      && !is_pf && !l2_acc_foreign;
    pf_miss = l2_acc_valid && !l2_acc_retry && l2_acc_miss && !l2_acc_line_pending
      && is_pf && !l2_acc_foreign;
    nxt_l2_ev = {(`PELB_THREADS*`PELB_L2_W){1'b0}};
    for (u = 0; u < `PELB_THREADS; u = u + 1) begin
      nxt_l2_ev[ev_idx(u, `PELB_L2_W, `PELB_EV_DM_LAT)] = dm_wait[u];
      nxt_l2_ev[ev_idx(u, `PELB_L2_W, `PELB_EV_PF_LAT)] = pf_wait[u];
    end
    // Only the requesting thread receives cache events.
    if (l2_acc_valid && !l2_acc_retry && !l2_acc_foreign) begin
      // Each pipeline flow reports separately, so multi-flow ops count per flow.
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_DM_REF)] =
        l2_acc_read && !is_pf;
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_PF_REF)] = is_pf;
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_DM_MISS)] = dm_miss;
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_PF_MISS)] = pf_miss;
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_DM_WB)] =
        dm_miss && l2_acc_writeback;
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_PF_WB)] =
        pf_miss && l2_acc_writeback;
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_IF_MISS)] =
        dm_miss && (l2_acc_kind == `PELB_KIND_FETCH);
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_SH_MISS)] =
        dm_miss && (l2_acc_kind == `PELB_KIND_SHARED);
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_EX_MISS)] =
        dm_miss && (l2_acc_kind == `PELB_KIND_EXCL);
      nxt_l2_ev[ev_idx(l2_acc_tid, `PELB_L2_W, `PELB_EV_EX_UPG)] =
        !l2_acc_miss && l2_acc_hit_shared_owned
        && (l2_acc_kind == `PELB_KIND_EXCL);
    end
    // Prefetch drops come from the storage unit with their own thread id.
    nxt_l2_ev[ev_idx(swpf_drop_tid, `PELB_L2_W, `PELB_EV_DROP_FULL)] =
      swpf_drop_full;
    nxt_l2_ev[ev_idx(swpf_drop_tid, `PELB_L2_W, `PELB_EV_DROP_ABORT)] =
      swpf_drop_abort;
  end

  // Bus events. Order-bus busy counts once per bus clock, sensed as a tick edge.
  always @* begin
    odr_edge = tick_s && !tick_d_ff;
    nxt_bus_ev = {`PELB_BUS_W{1'b0}};
    nxt_bus_ev[`PELB_EV_INV] = invalidations_received;
    nxt_bus_ev[`PELB_EV_CPI] = copy_invalidate_received;
    nxt_bus_ev[`PELB_EV_CPB] = copyback_received;
    nxt_bus_ev[`PELB_EV_IORD] = io_read_received;
    nxt_bus_ev[`PELB_EV_REP1] = reply_one_subline;
    nxt_bus_ev[`PELB_EV_REP4] = reply_four_sublines;
    for (b = 0; b < `PELB_BUSES; b = b + 1) begin
      nxt_bus_ev[`PELB_EV_ODR0 + b] = odr_edge && odr_busy_s[b];
      nxt_bus_ev[`PELB_EV_REQ0 + b] = req_busy_s[b];
    end
    // The aggregate bit is a strobe, set when any bus is busy; no output
    // carries the number of busy buses, so a cycle counts once.
    nxt_bus_ev[`PELB_EV_ODR_SUM] = odr_edge && (pop4(odr_busy_s) != 3'h0);
    nxt_bus_ev[`PELB_EV_REQ_SUM] = (pop4(req_busy_s) != 3'h0);
  end

  // Pairing events per thread; the sibling differs in the lowest id bit.
  always @* begin
    nxt_mt_ev = {(`PELB_THREADS*`PELB_MT_W){1'b0}};
    nxt_sgl_ins = {(`PELB_THREADS*`PELB_CMT_W){1'b0}};
    mate = {`PELB_TID_W{1'b0}};
    for (t = 0; t < `PELB_THREADS; t = t + 1) begin
      mate = t[`PELB_TID_W-1:0] ^ 3'h1;
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_SGL_CYC)] =
        thread_active[t] && thread_single_mode[t];
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_SGL_INS)] = thread_single_mode[t]
        && (commit_count[t*`PELB_CMT_W +: `PELB_CMT_W] != 3'h0);
      nxt_sgl_ins[t*`PELB_CMT_W +: `PELB_CMT_W] = thread_single_mode[t] ?
        commit_count[t*`PELB_CMT_W +: `PELB_CMT_W] : 3'h0;
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_BOTH_ACT)] = thread_active[t]
        && thread_active[mate] && commit_stack_nonempty[t]
        && commit_stack_nonempty[mate];
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_BOTH_EMP)] = thread_active[t]
        && thread_active[mate] && !commit_stack_nonempty[t]
        && !commit_stack_nonempty[mate];
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_BOTH_SUS)] =
        !thread_active[t] && !thread_active[mate];
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_ONLY_ME)] =
        thread_active[t] && !thread_active[mate];
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_ME_SUS)] = !thread_active[t];
      // The stall level is the commit stage's own view of the cycle.
      nxt_mt_ev[ev_idx(t, `PELB_MT_W, `PELB_EV_CMT_STALL)] =
        thread_active[t] && commit_stall[t];
    end
  end

  // All strobes leave from flops: most one cycle after their cause, latency two, synced bus busy three.
  always @(posedge clk) begin
    if (rst) begin
      tick_d_ff <= 1'b0;
      l2_ev_ff <= {(`PELB_THREADS*`PELB_L2_W){1'b0}};
      bus_ev_ff <= {`PELB_BUS_W{1'b0}};
      bus_ev_all_ff <= {`PELB_THREADS{1'b0}};
      mt_ev_ff <= {(`PELB_THREADS*`PELB_MT_W){1'b0}};
      sgl_ins_cnt_ff <= {(`PELB_THREADS*`PELB_CMT_W){1'b0}};
    end else begin
      tick_d_ff <= tick_s;
      l2_ev_ff <= nxt_l2_ev;
      bus_ev_ff <= nxt_bus_ev;
      // Any bus event goes to every thread's counter.
      bus_ev_all_ff <= {`PELB_THREADS{|nxt_bus_ev}};
      mt_ev_ff <= nxt_mt_ev;
      sgl_ins_cnt_ff <= nxt_sgl_ins;
    end
  end
endmodule
`default_nettype wire

// [verif/pelb_assertions.sv]
/*
  Checker for the event strobe block: ties miss, latency, reference, reply, invalidation, request-busy and pairing strobes to their cause a fixed
  number of cycles earlier. Assumes it is bound to pelb_event_gen, one
  access report per cycle, and the clk domain only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pelb_regs.vh"
module pelb_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic l2_acc_valid,
  input wire logic [`PELB_TID_W-1:0] l2_acc_tid,
  input wire logic l2_acc_sw_pf,
  input wire logic l2_acc_hw_pf,
  input wire logic l2_acc_l1_starved,
  input wire logic l2_acc_retry,
  input wire logic l2_acc_foreign,
  input wire logic l2_acc_miss,
  input wire logic l2_acc_line_pending,
  input wire logic reply_one_subline,
  input wire logic reply_four_sublines,
  input wire logic invalidations_received,
  input wire logic [`PELB_BUSES-1:0] request_bus_busy,
  input wire logic [`PELB_THREADS-1:0] thread_active,
  input wire logic [`PELB_THREADS-1:0] commit_stack_nonempty,
  input wire logic [`PELB_THREADS*`PELB_L2_W-1:0] l2_ev_ff,
  input wire logic [`PELB_BUS_W-1:0] bus_ev_ff,
  input wire logic [`PELB_THREADS-1:0] bus_ev_all_ff,
  input wire logic [`PELB_THREADS*`PELB_MT_W-1:0] mt_ev_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A flow that counts at all: retries and foreign requests never do.
  wire ok = l2_acc_valid && !l2_acc_retry && !l2_acc_foreign;
  // Any of the three qualifiers moves a flow to the prefetch class.
  wire pf = l2_acc_sw_pf || l2_acc_hw_pf || l2_acc_l1_starved;
  // Clean cycles since reset; the sync chain compare needs three of them.
  reg [2:0] up_ff;
  always @(posedge clk) up_ff <= rst ? 3'h0 : (up_ff == 3'h7 ? up_ff : up_ff + 3'h1);
  a_demand_miss_once: assert property (ok && !pf && l2_acc_miss && !l2_acc_line_pending
    |=> l2_ev_ff[$past(l2_acc_tid)*16+2] && !l2_ev_ff[$past(l2_acc_tid)*16+3])
    else $error("demand miss not flagged");
  a_pending_no_miss: assert property (l2_acc_valid && l2_acc_line_pending
    |=> !l2_ev_ff[$past(l2_acc_tid)*16+2]) else $error("pending line counted as miss");
  a_prefetch_class: assert property (ok && pf && l2_acc_miss && !l2_acc_line_pending
    |=> l2_ev_ff[$past(l2_acc_tid)*16+3] && !l2_ev_ff[$past(l2_acc_tid)*16+2])
    else $error("prefetch miss misclassed");
  a_demand_latency: assert property (ok && !pf && l2_acc_miss && !l2_acc_line_pending
    |-> ##2 l2_ev_ff[$past(l2_acc_tid, 2)*16]) else $error("miss wait not counting");
  a_retry_no_ref: assert property (l2_acc_valid && l2_acc_retry
    |=> !l2_ev_ff[$past(l2_acc_tid)*16+4]) else $error("retry counted");
  a_foreign_no_ref: assert property (l2_acc_valid && l2_acc_foreign
    |=> !l2_ev_ff[$past(l2_acc_tid)*16+4]) else $error("foreign request counted");
  a_reply_one_sub: assert property (reply_one_subline |=> bus_ev_ff[4])
    else $error("one-subline reply lost");
  a_reply_four_sub: assert property (reply_four_sublines |=> bus_ev_ff[5])
    else $error("four-subline reply lost");
  a_bus_all_threads: assert property (invalidations_received
    |=> bus_ev_ff[0] && bus_ev_all_ff == 8'hff) else $error("bus event not shared");
  a_req_busy_track: assert property (up_ff == 3'h7
    |-> bus_ev_ff[15:12] == $past(request_bus_busy, 3)
    && bus_ev_ff[7] == |$past(request_bus_busy, 3)) else $error("request bus busy mismatch");
  a_pair_both_busy: assert property (thread_active[1:0] == 2'h3
    && commit_stack_nonempty[1:0] == 2'h3 |=> mt_ev_ff[2] && mt_ev_ff[10])
    else $error("both active not seen");
  a_pair_both_empty: assert property (thread_active[3:2] == 2'h3
    && commit_stack_nonempty[3:2] == 2'h0 |=> mt_ev_ff[19] && mt_ev_ff[27])
    else $error("both empty not seen");
  c_demand_miss: cover property (ok && !pf && l2_acc_miss);
  c_prefetch: cover property (ok && pf);
  c_request_busy: cover property (request_bus_busy != 4'h0);
endmodule
bind pelb_event_gen pelb_assertions u_chk (.*);
`default_nettype wire

// [verif/pelb_bus_partner.sv]
/*
  Model of the system-bus side: makes the order-bus tick and busy levels.
  Assumes the bench raises run only while it wants order-bus cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pelb_bus_partner (
  input wire logic run,
  input wire logic [3:0] busy_cmd,
  output var logic [3:0] order_bus_busy,
  output var logic order_bus_tick,
  output var int ticks
);
  // The tick stands low between bursts.
  initial begin
    order_bus_busy = 4'h0;
    order_bus_tick = 1'h0;
    ticks = 0;
  end
  // A 12 ns half period holds each level over two core clocks, so the
  // synchroniser cannot miss it; busy moves only while the tick is low.
  always begin
    #12;
    if (order_bus_tick) begin
      order_bus_tick = 1'h0;
    end else if (run && order_bus_busy == busy_cmd) begin
      order_bus_tick = 1'h1;
      ticks = ticks + 1;
    end
    if (!order_bus_tick) begin
      order_bus_busy = run ? busy_cmd : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [verif/pelb_event_gen_bench.sv]
/*
  Self-checking bench for pelb_event_gen; one task per scenario.
  Assumes the bus partner model and the bound checker beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module pelb_event_gen_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic l2_acc_valid, l2_acc_sw_pf, l2_acc_hw_pf, l2_acc_l1_starved, l2_acc_read, l2_acc_retry;
  logic l2_acc_foreign, l2_acc_miss, l2_acc_line_pending, l2_acc_writeback;
  logic l2_acc_hit_shared_owned, l2_data_return, swpf_drop_full, swpf_drop_abort;
  logic invalidations_received, copy_invalidate_received, copyback_received, io_read_received;
  logic reply_one_subline, reply_four_sublines, order_bus_tick, run;
  logic [2:0] l2_acc_tid, l2_acc_miss_tag, l2_data_tag, swpf_drop_tid;
  logic [1:0] l2_acc_kind;
  logic [3:0] order_bus_busy, request_bus_busy, busy_cmd;
  logic [7:0] thread_active, thread_single_mode, commit_stack_nonempty, commit_stall;
  logic [23:0] commit_count;
  wire [127:0] l2_ev_ff;
  wire [15:0] bus_ev_ff;
  wire [7:0] bus_ev_all_ff;
  wire [63:0] mt_ev_ff;
  wire [23:0] sgl_ins_cnt_ff;
  int err_total = 0;
  int tests_run = 0;
  int pticks, cyc = 0;
  int n [16];
  pelb_event_gen dut (.*);
  pelb_bus_partner u_bus (.run(run), .busy_cmd(busy_cmd), .order_bus_busy(order_bus_busy),
    .order_bus_tick(order_bus_tick), .ticks(pticks));
  always #2.5 clk = ~clk;
  // Counts bus strobes; posedge sampling keeps it clear of negedge stimulus.
  always @(posedge clk) for (int i = 0; i < 16; i++) n[i] += bus_ev_ff[i];
  // A hang ends the run as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end
  function logic lb(int t, int b);
    return l2_ev_ff[t*16+b];
  endfunction
  // Drops every cache, drop and bus-event strobe and field back to zero; levels keep their value.
  task idle;
    {l2_acc_valid, l2_acc_sw_pf, l2_acc_hw_pf, l2_acc_l1_starved, l2_acc_read, l2_acc_retry,
     l2_acc_foreign, l2_acc_miss, l2_acc_line_pending, l2_acc_writeback, l2_acc_hit_shared_owned,
     l2_data_return, swpf_drop_full, swpf_drop_abort, invalidations_received,
     copy_invalidate_received, copyback_received, io_read_received, reply_one_subline,
     reply_four_sublines, l2_acc_tid, l2_acc_miss_tag, l2_data_tag, swpf_drop_tid,
     l2_acc_kind} = '0;
  endtask
  // One flow; returns where its strobes are visible.
  task fire;
    l2_acc_valid = 1'h1;
    @(negedge clk);
    idle();
  endtask
  task t_miss;
    int w;
    l2_acc_tid = 3'h2;
    l2_acc_read = 1'h1;
    l2_acc_miss = 1'h1;
    l2_acc_miss_tag = 3'h5;
    l2_acc_writeback = 1'h1;
    fire();
    `CHK({lb(2,2), lb(2,6), lb(2,8), lb(2,3), lb(2,7)}, 5'h1c)
    w = 0;
    repeat (6) begin
      @(negedge clk);
      w += lb(2,0);
    end
    l2_data_return = 1'h1;
    l2_data_tag = 3'h5;
    @(negedge clk);
    l2_data_return = 1'h0;
    repeat (4) begin
      w += lb(2,0);
      @(negedge clk);
    end
    `CHK(w, 7)
  endtask
  task t_pf;
    for (int k = 0; k < 3; k++) begin
      // An edge passes after each flow, so no input is driven twice in one step.
      @(negedge clk);
      {l2_acc_sw_pf, l2_acc_hw_pf, l2_acc_l1_starved} = 3'h1 << k;
      l2_acc_tid = 3'(k + 4);
      l2_acc_miss = 1'h1;
      l2_acc_writeback = 1'h1;
      l2_acc_miss_tag = 3'(k);
      fire();
      `CHK({lb(k+4,3), lb(k+4,7), lb(k+4,2), lb(k+4,6)}, 4'hc)
      @(negedge clk);
      {l2_acc_sw_pf, l2_acc_hw_pf, l2_acc_l1_starved} = 3'h1 << k;
      l2_acc_tid = 3'(k + 4);
      fire();
      `CHK({lb(k+4,5), lb(k+4,4)}, 2'h2)
      // The miss above still waits for data, so only prefetch latency runs.
      `CHK({lb(k+4,1), lb(k+4,0)}, 2'h2)
    end
  endtask
  task t_refs;
    @(negedge clk);
    l2_acc_tid = 3'h1;
    l2_acc_read = 1'h1;
    l2_acc_valid = 1'h1;
    @(negedge clk);
    `CHK(lb(1,4), 1'h1)
    fire();
    `CHK(lb(1,4), 1'h1)
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      {l2_acc_foreign, l2_acc_retry} = 2'h1 << k;
      l2_acc_tid = 3'h1;
      l2_acc_read = 1'h1;
      fire();
      `CHK(lb(1,4), 1'h0)
    end
    @(negedge clk);
    l2_acc_tid = 3'h1;
    l2_acc_miss = 1'h1;
    l2_acc_line_pending = 1'h1;
    fire();
    `CHK(lb(1,2), 1'h0)
  endtask
  task t_kinds;
    for (int k = 1; k < 3; k++) begin
      @(negedge clk);
      l2_acc_tid = 3'h3;
      l2_acc_kind = 2'(k);
      l2_acc_miss = 1'h1;
      l2_acc_miss_tag = 3'(k + 5);
      fire();
      `CHK({lb(3,10), lb(3,9), lb(3,8)}, 3'(1 << k))
    end
    @(negedge clk);
    l2_acc_tid = 3'h3;
    l2_acc_kind = 2'h2;
    l2_acc_hit_shared_owned = 1'h1;
    fire();
    `CHK(lb(3,11), 1'h1)
    @(negedge clk);
    swpf_drop_tid = 3'h7;
    swpf_drop_full = 1'h1;
    @(negedge clk);
    // Each drop strobe stands for the one cycle after its cause.
    `CHK({lb(7,13), lb(7,12)}, 2'h1)
    swpf_drop_full = 1'h0;
    swpf_drop_abort = 1'h1;
    @(negedge clk);
    `CHK({lb(7,13), lb(7,12)}, 2'h2)
    idle();
  endtask
  task t_bus;
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      {invalidations_received, copy_invalidate_received, copyback_received, io_read_received,
       reply_one_subline, reply_four_sublines} = 6'h20 >> k;
      @(negedge clk);
      idle();
      `CHK({bus_ev_all_ff, bus_ev_ff[5:0]}, {8'hff, 6'(1 << k)})
    end
  endtask
  task t_busy;
    n = '{default: 0};
    request_bus_busy = 4'ha;
    repeat (6) @(negedge clk);
    request_bus_busy = 4'h0;
    repeat (10) @(negedge clk);
    `CHK({n[7], n[12] + n[14], n[13] + n[15]}, {32'h6, 32'h0, 32'hc})
    n = '{default: 0};
    busy_cmd = 4'h5;
    run = 1'h1;
    for (int i = 0; i < 300 && pticks < 4; i++) @(negedge clk);
    run = 1'h0;
    repeat (20) @(negedge clk);
    `CHK({n[6], n[9] + n[11], n[8] + n[10]}, {pticks, 32'h0, 2 * pticks})
  endtask
  task t_thr;
    thread_active = 8'h1f;
    commit_stack_nonempty = 8'h03;
    thread_single_mode = 8'h10;
    commit_stall = 8'h01;
    commit_count = 24'h003000;
    @(negedge clk);
    `CHK(mt_ev_ff, 64'h5050_4023_0808_0484)
    `CHK(sgl_ins_cnt_ff, 24'h003000)
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    idle();
    {run, busy_cmd, request_bus_busy, thread_active, thread_single_mode} = '0;
    {commit_stack_nonempty, commit_stall, commit_count} = '0;
    repeat (10) @(negedge clk);
    rst = 1'h0;
    t_miss();
    t_pf();
    t_refs();
    t_kinds();
    t_bus();
    t_busy();
    t_thr();
    tally_and_finish();
  end
endmodule
`default_nettype wire
